// ===== logic/sfp_host.v
/*
  Host controller for a byte-wide sector flash: array reads, unlocked
  128-byte sector programming and completion polling on data bit 7.
  Assumes the flash pins are wired straight to the pin ports and the
  bidirectional data wire is resolved outside from data_oe_o.
*/
`timescale 1ns/1ps
`include "sfp_host_regs.vh"

// Behaviour
// R1: Read with select and gate low, strobe high
// R2: Flash floats data when select/gate high
// R3: 1024 sectors of 128 bytes each
// R4: Three unlock commands before each sector program
// R5: Unlocked-less write only starts timer, no change
// R6: Byte load by strobe pulse, gate high
// R7: Flash latches address on later falling edge
// R8: Flash latches data on earlier rising edge
// R9: Unloaded bytes read FFh, so load all
// R10: Next load within 150 us of previous
// R11: Load window expiry starts internal programming
// R12: High address bits pick sector, held stable
// R13: Low address bits pick byte, any order
// R14: Flash erases then programs sector itself
// R15: Reads during program cycle are status polls
// R16: Poll bit 7 until done before next access
// R17: Program cycle lasts at most 20 ms
// R18: Programming inhibited during power-up delay
// R19: No program with gate low or strobes high
// R20: Strobe pulses under 15 ns are ignored
// R21: Protection state survives power transitions
// R22: Polled last byte shows inverted bit 7
// R23: Bit 6 toggles while programming runs
// R24: Unlock addresses and data are shared parameters
// R25: Timeouts are configurable cycle counts
module sfp_host
#(
  parameter [19:0] POWERUP_CYC = `SFP_POWERUP_CYC,
  parameter [19:0] PROGRAM_CYC = `SFP_PROGRAM_CYC
)
(
  // Clock and reset
  input  wire        clock_i,
  input  wire        rst_i,
  // User read port
  input  wire        rd_req_i,
  input  wire [16:0] rd_addr_i,
  output reg  [7:0]  rd_data_o,
  output reg         rd_valid_o,
  // User program port
  input  wire        buf_wr_i,
  input  wire [6:0]  buf_idx_i,
  input  wire [7:0]  buf_data_i,
  input  wire        prog_req_i,
  input  wire [9:0]  prog_sector_i,
  output reg         prog_done_o,
  output reg         prog_timeout_o,
  // Status
  output wire        ready_o,
  output wire        busy_o,
  // Flash pins
  output reg  [16:0] addr_o,
  output reg         chip_select_n_o,
  output reg         output_gate_n_o,
  output reg         write_strobe_n_o,
  output reg  [7:0]  data_o,
  output reg         data_oe_o,
  input  wire [7:0]  data_i
);

  // ****************************************
  // Declarations
  // ****************************************
  reg  [7:0]  state_q;       // One-hot state
  reg  [19:0] cnt_q;         // Phase counter
  reg  [19:0] tmo_q;         // Program cycle timeout counter
  reg  [7:0]  step_q;        // Write step: 0..2 unlock, 3..130 bytes
  reg  [9:0]  sector_q;      // Latched sector number
  reg         last_b7_q;     // Bit 7 of last byte loaded
  reg  [7:0]  sync1_q;       // Data input synchroniser stage 1
  reg  [7:0]  sync2_q;       // Stage 2
  reg  [7:0]  sync3_q;       // Stage 3
  reg  [7:0]  din_q;         // Accepted data input
  wire [7:0]  byte_step;     // Step minus unlock steps
  wire [6:0]  buf_rd_idx;    // Buffer read index
  wire [7:0]  buf_rd_data;   // Buffer read data

  assign byte_step  = step_q - `SFP_UNLOCK_STEPS;
  assign buf_rd_idx = byte_step[6:0];
  assign ready_o    = (state_q == `SFP_S_IDLE);
  assign busy_o     = ~ready_o;

  // ****************************************
  // Step decoding
  // ****************************************
  // Address driven for a write step
  function [16:0] step_addr;
    input [7:0] step;
    input [9:0] sector;
    input [6:0] idx;
    begin
      case (step)
        8'h00:   step_addr = `SFP_UNLK_A0;  // R24
        8'h01:   step_addr = `SFP_UNLK_A1;
        8'h02:   step_addr = `SFP_UNLK_A2;
        default: step_addr = {sector, idx};  // R12 R13
      endcase
    end
  endfunction

  // Data driven for a write step
  function [7:0] step_data;
    input [7:0] step;
    input [7:0] bdata;
    begin
      case (step)
        8'h00:   step_data = `SFP_UNLK_D0;  // R24
        8'h01:   step_data = `SFP_UNLK_D1;
        8'h02:   step_data = `SFP_UNLK_D2;
        default: step_data = bdata;
      endcase
    end
  endfunction

  // ****************************************
  // Sector staging buffer
  // ****************************************
  sfp_sector_buf u_buf
  (
    .clock_i   (clock_i),
    .wr_en_i   (buf_wr_i & ready_o),
    .wr_idx_i  (buf_idx_i),
    .wr_data_i (buf_data_i),
    .rd_idx_i  (buf_rd_idx),
    .rd_data_o (buf_rd_data)
  );

  // ****************************************
  // Data pin synchroniser
  // ****************************************
  // Accept a value once stages 2 and 3 agree
  always @(posedge clock_i)
  begin
    if (rst_i)
    begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
      sync3_q <= 8'h00;
      din_q   <= 8'h00;
    end
    else
    begin
      sync1_q <= data_i;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      if (sync2_q == sync3_q)
      begin
        din_q <= sync3_q;
      end
    end
  end

  // ****************************************
  // Main sequencer
  // ****************************************
  always @(posedge clock_i)
  begin
    if (rst_i)
    begin
      state_q          <= `SFP_S_PWR;
      cnt_q            <= 20'h00000;
      tmo_q            <= 20'h00000;
      step_q           <= 8'h00;
      sector_q         <= 10'h000;
      last_b7_q        <= 1'b0;
      addr_o           <= 17'h00000;
      chip_select_n_o  <= 1'b1;
      output_gate_n_o  <= 1'b1;
      write_strobe_n_o <= 1'b1;
      data_o           <= 8'h00;
      data_oe_o        <= 1'b0;
      rd_data_o        <= 8'h00;
      rd_valid_o       <= 1'b0;
      prog_done_o      <= 1'b0;
      prog_timeout_o   <= 1'b0;
    end
    else
    begin
      rd_valid_o     <= 1'b0;
      prog_done_o    <= 1'b0;
      prog_timeout_o <= 1'b0;
      case (state_q)
        // Wait out flash power-up before any access
        `SFP_S_PWR:
        begin
          cnt_q <= cnt_q + 20'h00001;
          if (cnt_q >= POWERUP_CYC)  // R18 R25
          begin
            cnt_q   <= 20'h00000;
            state_q <= `SFP_S_IDLE;
          end
        end
        // Pins idle, flash deselected and data floated
        `SFP_S_IDLE:
        begin
          cnt_q <= 20'h00000;
          if (prog_req_i)
          begin
            sector_q        <= prog_sector_i;
            step_q          <= 8'h00;
            output_gate_n_o <= 1'b1;  // R19
            chip_select_n_o <= 1'b0;
            data_oe_o       <= 1'b1;
            state_q         <= `SFP_S_FETCH;  // R4
          end
          else if (rd_req_i)
          begin
            addr_o          <= rd_addr_i;
            chip_select_n_o <= 1'b0;  // R1
            output_gate_n_o <= 1'b0;
            state_q         <= `SFP_S_RD;
          end
        end
        // Array read: wait access time plus synchroniser
        `SFP_S_RD:
        begin
          cnt_q <= cnt_q + 20'h00001;
          if (cnt_q == `SFP_RD_WAIT_CYC)
          begin
            rd_data_o       <= din_q;
            rd_valid_o      <= 1'b1;
            chip_select_n_o <= 1'b1;  // R2
            output_gate_n_o <= 1'b1;
            state_q         <= `SFP_S_IDLE;
          end
        end
        // Set address for the step; buffer read settles
        `SFP_S_FETCH:
        begin
          addr_o  <= step_addr(step_q, sector_q, buf_rd_idx);  // R12 R13
          cnt_q   <= 20'h00000;
          state_q <= `SFP_S_WLO;
        end
        // Strobe low; address latched on this fall
        `SFP_S_WLO:
        begin
          write_strobe_n_o <= 1'b0;  // R6 R7
          data_o           <= step_data(step_q, buf_rd_data);
          cnt_q            <= cnt_q + 20'h00001;
          if (step_q == `SFP_LAST_STEP)
          begin
            last_b7_q <= buf_rd_data[7];
          end
          if (cnt_q == `SFP_WE_LOW_CYC)  // R20
          begin
            write_strobe_n_o <= 1'b1;  // R8
            cnt_q            <= 20'h00000;
            state_q          <= `SFP_S_WHI;
          end
        end
        // Strobe high; data held, gap far below load window
        `SFP_S_WHI:
        begin
          cnt_q <= cnt_q + 20'h00001;
          if (cnt_q == `SFP_WE_HIGH_CYC)
          begin
            cnt_q <= 20'h00000;
            if (step_q == `SFP_LAST_STEP)  // R9 R10
            begin
              data_oe_o <= 1'b0;
              tmo_q     <= 20'h00000;
              addr_o    <= {sector_q, 7'h7F};
              state_q   <= `SFP_S_PGAP;  // R11 R14
            end
            else
            begin
              step_q  <= step_q + 8'h01;
              state_q <= `SFP_S_FETCH;
            end
          end
        end
        // Status poll of the last byte loaded
        `SFP_S_POLL:
        begin
          cnt_q <= cnt_q + 20'h00001;
          tmo_q <= tmo_q + 20'h00001;
          if (cnt_q == `SFP_RD_WAIT_CYC)  // R15
          begin
            output_gate_n_o <= 1'b1;
            cnt_q           <= 20'h00000;
            if (din_q[7] == last_b7_q)  // R16 R22
            begin
              chip_select_n_o <= 1'b1;
              prog_done_o     <= 1'b1;
              state_q         <= `SFP_S_IDLE;
            end
            else if (tmo_q >= PROGRAM_CYC)  // R17 R25
            begin
              chip_select_n_o <= 1'b1;
              prog_timeout_o  <= 1'b1;
              state_q         <= `SFP_S_IDLE;
            end
            else
            begin
              state_q <= `SFP_S_PGAP;
            end
          end
        end
        // Gate high between polls
        `SFP_S_PGAP:
        begin
          cnt_q <= cnt_q + 20'h00001;
          tmo_q <= tmo_q + 20'h00001;
          if (cnt_q == `SFP_POLL_GAP_CYC)
          begin
            output_gate_n_o <= 1'b0;
            cnt_q           <= 20'h00000;
            state_q         <= `SFP_S_POLL;
          end
        end
        // Illegal code: recover to idle
        default:
        begin
          chip_select_n_o  <= 1'b1;
          output_gate_n_o  <= 1'b1;
          write_strobe_n_o <= 1'b1;
          data_oe_o        <= 1'b0;
          state_q          <= `SFP_S_IDLE;
        end
      endcase
    end
  end

endmodule

// ===== logic/sfp_host_regs.vh
/*
  Constants of the sector flash programming host: pin timing, timeouts,
  unlock command values and state codes.
  Assumes a 40 MHz system clock and a flash with 128-byte sectors.
*/
`ifndef SFP_HOST_REGS_VH
`define SFP_HOST_REGS_VH

// ****************************************
// Clock and pin timing
// ****************************************
`define SFP_CLK_PERIOD_NS  25
`define SFP_T_ACCESS_NS    150
`define SFP_ACCESS_CYC     ((`SFP_T_ACCESS_NS + `SFP_CLK_PERIOD_NS - 1) / `SFP_CLK_PERIOD_NS)
`define SFP_SYNC_CYC       4
`define SFP_RD_WAIT_CYC    (`SFP_ACCESS_CYC + `SFP_SYNC_CYC)
`define SFP_T_WE_LOW_NS    100
`define SFP_WE_LOW_CYC     ((`SFP_T_WE_LOW_NS + `SFP_CLK_PERIOD_NS - 1) / `SFP_CLK_PERIOD_NS)
`define SFP_T_WE_HIGH_NS   100
`define SFP_WE_HIGH_CYC    ((`SFP_T_WE_HIGH_NS + `SFP_CLK_PERIOD_NS - 1) / `SFP_CLK_PERIOD_NS)
`define SFP_POLL_GAP_CYC   2

// ****************************************
// Long waits (power-up and program are defaults of top parameters)
// ****************************************
`define SFP_T_POWERUP_US   20000
`define SFP_POWERUP_CYC    ((`SFP_T_POWERUP_US * 1000) / `SFP_CLK_PERIOD_NS)
`define SFP_T_PROGRAM_US   20000
`define SFP_PROGRAM_CYC    ((`SFP_T_PROGRAM_US * 1000) / `SFP_CLK_PERIOD_NS)
`define SFP_T_LOAD_WIN_US  150

// ****************************************
// Sector geometry and load sequence
// ****************************************
`define SFP_SECTOR_BYTES   128
`define SFP_UNLOCK_STEPS   8'h03
`define SFP_LAST_STEP      8'h82

// ****************************************
// Unlock commands (arbitrary defaults)
// ****************************************
`define SFP_UNLK_A0        17'h00001
`define SFP_UNLK_D0        8'h11
`define SFP_UNLK_A1        17'h00002
`define SFP_UNLK_D1        8'h22
`define SFP_UNLK_A2        17'h00003
`define SFP_UNLK_D2        8'h33

// ****************************************
// One-hot state codes
// ****************************************
`define SFP_S_PWR          8'h01
`define SFP_S_IDLE         8'h02
`define SFP_S_RD           8'h04
`define SFP_S_FETCH        8'h08
`define SFP_S_WLO          8'h10
`define SFP_S_WHI          8'h20
`define SFP_S_POLL         8'h40
`define SFP_S_PGAP         8'h80

`endif

// ===== logic/sfp_sector_buf.v
/*
  Sector staging buffer: 128 x 8 bits, one write port, one registered
  read port. Assumes the same clock as the host controller.
*/
`timescale 1ns/1ps

module sfp_sector_buf
(
  // Clock
  input  wire       clock_i,
  // Write port
  input  wire       wr_en_i,
  input  wire [6:0] wr_idx_i,
  input  wire [7:0] wr_data_i,
  // Read port
  input  wire [6:0] rd_idx_i,
  output reg  [7:0] rd_data_o
);

  reg [7:0] mem_q [0:127];  // Byte storage

  // ****************************************
  // Write and registered read
  // ****************************************
  always @(posedge clock_i)
  begin
    if (wr_en_i)
    begin
      mem_q[wr_idx_i] <= wr_data_i;
    end
    rd_data_o <= mem_q[rd_idx_i];
  end

endmodule

// ===== tb/sfp_host_assertions.sv
/* Pin checker of the flash host.
   Bound to sfp_host from the bench top. */
`timescale 1ns/1ps
`include "sfp_host_regs.vh"
module sfp_host_assertions
(
  input wire logic        clock_i,
  input wire logic        rst_i,
  input wire logic        rd_req_i,
  input wire logic        prog_req_i,
  input wire logic        ready_o,
  input wire logic        rd_valid_o,
  input wire logic        prog_done_o,
  input wire logic [16:0] addr_o,
  input wire logic        chip_select_n_o,
  input wire logic        output_gate_n_o,
  input wire logic        write_strobe_n_o,
  input wire logic [7:0]  data_o,
  input wire logic        data_oe_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  property p_load_ctl;
    !write_strobe_n_o |-> !chip_select_n_o && output_gate_n_o;
  endproperty
  a_load_ctl: assert property (p_load_ctl) else $error("load without select");
  property p_no_clash;
    !output_gate_n_o |-> write_strobe_n_o && !data_oe_o;
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("drive while read");
  property p_first_cmd;
    $fell(write_strobe_n_o) && $past(ready_o, 3)
      |-> addr_o == `SFP_UNLK_A0 && data_o == `SFP_UNLK_D0;
  endproperty
  a_first_cmd: assert property (p_first_cmd) else $error("bad unlock start");
  property p_hold;
    !write_strobe_n_o && $past(!write_strobe_n_o) |-> $stable(addr_o) && $stable(data_o);
  endproperty
  a_hold: assert property (p_hold) else $error("addr moved in load");
  property p_gap;
    $rose(write_strobe_n_o) |-> ##[1:12] ($fell(write_strobe_n_o) || !output_gate_n_o);
  endproperty
  a_gap: assert property (p_gap) else $error("load gap too long");
  property p_done;
    prog_done_o |-> chip_select_n_o && output_gate_n_o;
  endproperty
  a_done: assert property (p_done) else $error("select after done");
  property p_rd_lat;
    ready_o && rd_req_i && !prog_req_i |-> ##12 rd_valid_o;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read latency");
endmodule

// ===== tb/sfp_flash_model.sv
/* Behavioural byte-wide sector flash, clockless.
   The bench resolves the data wire from drive_o. */
`timescale 1ns/1ps
`include "sfp_host_regs.vh"
module sfp_flash_model
#(
  parameter int WIN_NS = 1000,
  parameter int PWR_NS = 200
)
(
  input  wire logic [16:0] addr_i,
  input  wire logic        cs_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic [7:0]  din_i,
  output logic      [7:0]  dout_o,
  output logic             drive_o
);
  logic [7:0]  mem [0:131071];
  logic [7:0]  ld [0:127];
  bit          hit [0:127];
  logic [16:0] la_q;
  logic [9:0]  sec_q;
  logic [7:0]  last_q;
  logic        tog_q = 0;
  logic [16:0] ua [3] = '{`SFP_UNLK_A0, `SFP_UNLK_A1, `SFP_UNLK_A2};
  logic [7:0]  ud [3] = '{`SFP_UNLK_D0, `SFP_UNLK_D1, `SFP_UNLK_D2};
  int          prog_ns = 5000;
  int          step = 0;
  int          nld = 0;
  bit          busy = 0, bad = 0;
  time         tf = 0, tr = 0;
  wire         wr_n = cs_n_i | we_n_i | !oe_n_i;
  // Sector cycle: erase then program
  task automatic run();
    int i;
    busy = 1;
    #(prog_ns);
    for (i = 0; i < 128; i++)
    begin
      if (!bad) mem[{sec_q, i[6:0]}] = hit[i] ? ld[i] : 8'hFF;
      hit[i] = 0;
    end
    {busy, bad, step, nld} = 0;
  endtask
  // Load window watch
  initial
  begin
    foreach (mem[i]) mem[i] = 8'hFF;
    forever
    begin
      #50;
      if (nld > 0 && !busy && $time - tr > WIN_NS) run();
    end
  end
  always @(negedge wr_n)
  begin
    tf = $time;
    la_q = addr_i;
  end
  always @(posedge wr_n)
  begin
    if ($time - tf >= 15 && $time >= PWR_NS && !busy)
    begin
      tr = $time;
      last_q = din_i;
      if (step < 3 && la_q == ua[step] && din_i == ud[step]) step++;
      else if (step < 3)
      begin
        bad = 1;
        nld = 1;
      end
      else
      begin
        ld[la_q[6:0]] = din_i;
        hit[la_q[6:0]] = 1;
        sec_q = la_q[16:7];
        nld++;
      end
    end
  end
  always @(posedge oe_n_i) tog_q = ~tog_q;
  // Reads are status polls from the first load until the cycle ends
  always_comb
  begin
    drive_o = !cs_n_i && !oe_n_i && we_n_i;
    if (busy || nld > 0) dout_o = {~last_q[7], tog_q, last_q[5:0]};
    else dout_o = mem[addr_i];
  end
endmodule

// ===== tb/testbench.sv
/* Bench of the flash host: flash model, expected memory, random data.
   Assumes checker and model files are compiled first. */
`timescale 1ns/1ps
module testbench;
  logic        clock_i = 0, rst_i = 1, rd_req_i = 0, buf_wr_i = 0, prog_req_i = 0;
  logic [16:0] rd_addr_i = 0;
  logic [6:0]  buf_idx_i = 0;
  logic [7:0]  buf_data_i = 0, float_q = 8'h5A;
  logic [9:0]  prog_sector_i = 0;
  logic [9:0]  sec [3] = '{10'h000, 10'h3FF, 10'h155};
  wire  [7:0]  rd_data_o, data_o, fd;
  wire  [16:0] addr_o;
  wire         rd_valid_o, prog_done_o, prog_timeout_o, ready_o, busy_o, cs_n, oe_n, we_n;
  wire         data_oe_o, fdrv;
  wire  [7:0]  pin = data_oe_o ? data_o : fdrv ? fd : float_q;
  int          n_errors = 0, check_count = 0, cyc = 0, i, seed = 32'h3b11;
  logic [7:0]  exp_mem [int];
  sfp_host #(.POWERUP_CYC(20'd20), .PROGRAM_CYC(20'd2000)) dut (.clock_i(clock_i),
    .rst_i(rst_i), .rd_req_i(rd_req_i), .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o), .buf_wr_i(buf_wr_i), .buf_idx_i(buf_idx_i),
    .buf_data_i(buf_data_i), .prog_req_i(prog_req_i), .prog_sector_i(prog_sector_i),
    .prog_done_o(prog_done_o), .prog_timeout_o(prog_timeout_o), .ready_o(ready_o),
    .busy_o(busy_o), .addr_o(addr_o), .chip_select_n_o(cs_n), .output_gate_n_o(oe_n),
    .write_strobe_n_o(we_n), .data_o(data_o), .data_oe_o(data_oe_o), .data_i(pin));
  sfp_flash_model #(.WIN_NS(1000), .PWR_NS(200)) fl (.addr_i(addr_o), .cs_n_i(cs_n),
    .oe_n_i(oe_n), .we_n_i(we_n), .din_i(pin), .dout_o(fd), .drive_o(fdrv));
  initial forever #12.5 clock_i = ~clock_i;
  // Released wire shows a moving pattern
  always @(posedge clock_i) float_q <= float_q + 8'h35;
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wait_rdy();
    do begin @(posedge clock_i); #1; end while (ready_o !== 1'b1);
    // Align to a rising edge so requests are driven on it
    @(posedge clock_i);
  endtask
  task automatic rd(input logic [16:0] a);
    logic [7:0] e;
    e = exp_mem.exists(a) ? exp_mem[a] : 8'hFF;
    wait_rdy();
    rd_req_i <= 1;
    rd_addr_i <= a;
    @(posedge clock_i);
    rd_req_i <= 0;
    repeat (11) @(posedge clock_i);
    #1;
    chk({7'h00, rd_valid_o}, 8'h01, "read valid");
    chk(rd_data_o, e, "read data");
    chk({7'h00, busy_o}, 8'h00, "busy after read");
  endtask
  task automatic prog(input logic [9:0] s, input bit slow);
    int k, nv;
    logic [7:0] d [128];
    wait_rdy();
    for (k = 0; k < 128; k++)
    begin
      d[k] = $random(seed);
      buf_wr_i <= 1;
      buf_idx_i <= k[6:0];
      buf_data_i <= d[k];
      @(posedge clock_i);
    end
    buf_wr_i <= 0;
    prog_req_i <= 1;
    prog_sector_i <= s;
    @(posedge clock_i);
    prog_req_i <= 0;
    rd_req_i <= 1;
    rd_addr_i <= 17'($random(seed));
    nv = 0;
    // Reads offered while busy must never be answered
    repeat (20)
    begin
      @(posedge clock_i);
      #1;
      nv += rd_valid_o;
    end
    rd_req_i <= 0;
    while (prog_done_o !== 1'b1 && prog_timeout_o !== 1'b1)
    begin
      @(posedge clock_i);
      #1;
      nv += rd_valid_o;
    end
    chk(nv[7:0], 8'h00, "read while busy");
    chk({7'h00, prog_timeout_o}, {7'h00, slow}, "program end");
    for (k = 0; k < 128; k++) exp_mem[{s, k[6:0]}] = d[k];
    $display("program of sector %h ended at %0t", s, $time);
  endtask
  initial
  begin
    repeat (10) @(posedge clock_i);
    rst_i <= 0;
    #1;
    chk({5'h00, cs_n, oe_n, we_n}, 8'h07, "idle pins");
    chk({7'h00, busy_o}, 8'h01, "busy in power-up");
    rd(17'h1FFFF);
    $display("first read ended at %0t", $time);
    prog(sec[0], 0);
    prog(sec[1], 0);
    fl.prog_ns = 80000;
    prog(sec[2], 1);
    #85000;
    fl.prog_ns = 5000;
    for (i = 0; i < 9; i++) rd({sec[i % 3], 7'($random(seed))});
    $display("readback ended at %0t", $time);
    stop_test();
  end
endmodule
bind sfp_host sfp_host_assertions u_chk (.clock_i(clock_i), .rst_i(rst_i),
  .rd_req_i(rd_req_i), .prog_req_i(prog_req_i), .ready_o(ready_o),
  .rd_valid_o(rd_valid_o), .prog_done_o(prog_done_o), .addr_o(addr_o),
  .chip_select_n_o(chip_select_n_o), .output_gate_n_o(output_gate_n_o),
  .write_strobe_n_o(write_strobe_n_o), .data_o(data_o), .data_oe_o(data_oe_o));
